/* File: core/css_consts.vh */
/*
 * constants of the compressor stage sequencer: register offsets, field
 * positions, reset values, encodings and timing figures.
 * assumes inclusion by bare name from the sequencer core only.
 */
// ****************************************************************
// Overview of operation
// - each compound runs as refrigerant compound or 1/2/3-circuit chiller, max 12.
// - refuse settings giving more than four refrigerant circuits over both compounds.
// - scale the normalized current-loop reading through a per-channel pressure range.
// - hysteresis band lies symmetric, above or below the working setpoint.
// - inside the band the state is neutral, no forward, no backrun.
// - above the band a forward command asks for more stages.
// - below the band a backrun command asks for fewer stages.
// - band compares always use the working setpoint, never the raw one.
// - working setpoint never exceeds the configured setpoint ceiling.
// - stages per compressor set; all configured stages are separate outputs.
// - every stage has its own forward and backrun delay.
// - forward switches next stage after its delay; each switch restarts timer.
// - entering neutral clears all delay timers and pending switching.
// - backrun times the backrun delay, then drops one stage, and repeats.
// - below prealarm threshold a warning is raised with a configurable class.
// - below alarm threshold every stage switches off at once.
// - forward, neutral or backrun state of each compound is readable.
// - utilization percent is the sum of shares of running compressors.
// - night-shift input active adds a signed offset to the setpoint.
// - enthalpy shift bounded by upper and lower temperature and humidity limits.
// - near upper limit no shift; near lower limit the full maximum shift.
// - in chiller types the shift applies to the temperature setpoint.
// ****************************************************************
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
// ****************************************************************
// register offsets and address layout
// ****************************************************************
`define CSS_OFF_CFG     6'h00
`define CSS_OFF_SETP    6'h04
`define CSS_OFF_LIM     6'h08
`define CSS_OFF_THR     6'h0C
`define CSS_OFF_RNG     6'h10
`define CSS_OFF_ENL     6'h14
`define CSS_OFF_SHF     6'h18
`define CSS_OFF_STAT    6'h1C
`define CSS_OFF_VAL     6'h20
`define CSS_CMP_BIT     7
`define CSS_STG_BIT     6
// ****************************************************************
// decode results
// ****************************************************************
`define CSS_DEC_CFG     4'h0
`define CSS_DEC_SETP    4'h1
`define CSS_DEC_LIM     4'h2
`define CSS_DEC_THR     4'h3
`define CSS_DEC_RNG     4'h4
`define CSS_DEC_ENL     4'h5
`define CSS_DEC_SHF     4'h6
`define CSS_DEC_STAT    4'h7
`define CSS_DEC_VAL     4'h8
`define CSS_DEC_STAGE   4'h9
`define CSS_DEC_NONE    4'hF
// ****************************************************************
// field positions
// ****************************************************************
`define CSS_CFG_PLANT   1:0
`define CSS_CFG_PLACE   3:2
`define CSS_CFG_TOTAL   8:4
`define CSS_CFG_PER     11:9
`define CSS_CFG_ENTH    12
`define CSS_STG_FWD     0
`define CSS_STG_BCK     12
`define CSS_STG_SHARE   24
// ****************************************************************
// reset values and encodings
// ****************************************************************
`define CSS_CFG_RST     32'h0000_0000
`define CSS_REG_RST     32'h0000_0000
`define CSS_RNG_RST     32'hFFFF_0000
`define CSS_LIM_RST     32'h0000_FFFF
`define CSS_PLANT_REFR  2'h0
`define CSS_PLACE_SYM   2'h0
`define CSS_PLACE_ABV   2'h1
`define CSS_PLACE_BLW   2'h2
`define CSS_MAX_CIRC    3'h4
`define CSS_MAX_COMPR   5'h0C
// ****************************************************************
// timing
// ****************************************************************
`define CSS_TICK_MS     100
`define CSS_CLK_KHZ     25000
`endif

/* File: core/css_sequencer.v */
/*
 * compressor stage sequencer for two compounds with apb register access.
 * assumes analog readings, plant sensors and night input arrive asynchronously
 * and stage outputs drive relays through external buffers.
 */
`timescale 1ns/1ps
`include "css_consts.vh"
module css_sequencer #(
   parameter MAX_STAGES  = 12,
   parameter TICK_CYCLES = `CSS_TICK_MS * `CSS_CLK_KHZ
) (
   // clock, reset, enable
   input  wire                      pclk,
   input  wire                      presetn,
   input  wire                      ce,
   // apb slave
   input  wire                      psel,
   input  wire                      penable,
   input  wire                      pwrite,
   input  wire [11:0]               paddr,
   input  wire [31:0]               pwdata,
   output wire [31:0]               prdata,
   output wire                      pready,
   output wire                      pslverr,
   // plant inputs, two compounds
   input  wire [23:0]               suction_raw,
   input  wire [23:0]               brine_temp_raw,
   input  wire [15:0]               plant_temp,
   input  wire [15:0]               plant_hum,
   input  wire [1:0]                night_shift_input,
   // stage relays and status
   output wire [2*MAX_STAGES-1:0]   stage_on,
   output wire [1:0]                forward_cmd,
   output wire [1:0]                backrun_cmd,
   output wire [1:0]                prealarm_warn,
   output wire [3:0]                prealarm_prio,
   output wire [1:0]                hazard_return,
   output wire [19:0]               utilization_pct
);
   // ****************************************************************
   // states and helpers
   // ****************************************************************
   localparam [2:0] ST_NEU = 3'b001;
   localparam [2:0] ST_FWD = 3'b010;
   localparam [2:0] ST_BCK = 3'b100;

   function [3:0] css_dec;
      input [11:0] a;
      begin
         css_dec = `CSS_DEC_NONE;
         if (a[11:8] == 4'h0 && a[1:0] == 2'b00)
         begin
            if (a[`CSS_STG_BIT])
            begin
               if ({28'h0000000, a[5:2]} < MAX_STAGES)
                  css_dec = `CSS_DEC_STAGE;
            end
            else
            begin
               case (a[5:0])
                  `CSS_OFF_CFG:  css_dec = `CSS_DEC_CFG;
                  `CSS_OFF_SETP: css_dec = `CSS_DEC_SETP;
                  `CSS_OFF_LIM:  css_dec = `CSS_DEC_LIM;
                  `CSS_OFF_THR:  css_dec = `CSS_DEC_THR;
                  `CSS_OFF_RNG:  css_dec = `CSS_DEC_RNG;
                  `CSS_OFF_ENL:  css_dec = `CSS_DEC_ENL;
                  `CSS_OFF_SHF:  css_dec = `CSS_DEC_SHF;
                  `CSS_OFF_STAT: css_dec = `CSS_DEC_STAT;
                  `CSS_OFF_VAL:  css_dec = `CSS_DEC_VAL;
                  default:       css_dec = `CSS_DEC_NONE;
               endcase
            end
         end
      end
   endfunction

   // circuits used by a plant type
   function [2:0] css_circ;
      input [1:0] plant;
      begin
         css_circ = (plant == `CSS_PLANT_REFR) ? 3'h1 : {1'b0, plant};
      end
   endfunction

   // stage i opens a new compressor
   function css_first;
      input integer i;
      input [2:0]   per;
      integer       p;
      begin
         p = (per == 3'h0) ? 1 : per;
         css_first = ((i % p) == 0);
      end
   endfunction

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   reg  [81:0] sync1_reg;
   reg  [81:0] sync2_reg;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_reg <= 82'h0;
         sync2_reg <= 82'h0;
      end
      else if (ce)
      begin
         sync1_reg <= {night_shift_input, plant_hum, plant_temp, brine_temp_raw, suction_raw};
         sync2_reg <= sync1_reg;
      end
   end

   // ****************************************************************
   // delay tick prescaler
   // ****************************************************************
   reg  [31:0] pre_reg;
   wire        tick = (pre_reg == TICK_CYCLES - 1);
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre_reg <= 32'h0;
      else if (ce)
         pre_reg <= tick ? 32'h0 : pre_reg + 32'h1;
   end

   // ****************************************************************
   // apb slave
   // ****************************************************************
   wire [3:0]  dec = css_dec(paddr);
   wire [63:0] cfg_all;
   wire [63:0] rd_all;
   reg         ack_reg;
   reg         err_reg;
   reg  [31:0] prdata_reg;
   wire [31:0] other_cfg = paddr[`CSS_CMP_BIT] ? cfg_all[31:0] : cfg_all[63:32];
   wire [3:0]  circ_sum  = {1'b0, css_circ(pwdata[`CSS_CFG_PLANT])}
                         + {1'b0, css_circ(other_cfg[`CSS_CFG_PLANT])};
   wire        cfg_bad   = (circ_sum > {1'b0, `CSS_MAX_CIRC});
   wire        ro_hit    = (dec == `CSS_DEC_STAT) || (dec == `CSS_DEC_VAL);
   wire        bad_acc   = (dec == `CSS_DEC_NONE)
                         || (pwrite && ro_hit)
                         || (pwrite && dec == `CSS_DEC_CFG && cfg_bad);
   wire        apb_wr    = psel & penable & ack_reg & pwrite & ~err_reg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ack_reg    <= 1'b0;
         err_reg    <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end
      else if (ce)
      begin
         ack_reg <= psel & penable & ~ack_reg;
         if (psel && penable && !ack_reg)
         begin
            err_reg    <= bad_acc;
            prdata_reg <= (pwrite || bad_acc) ? 32'h0000_0000 :
                          (paddr[`CSS_CMP_BIT] ? rd_all[63:32] : rd_all[31:0]);
         end
         else
         begin
            err_reg <= 1'b0;
         end
      end
   end

   assign pready  = ack_reg;
   assign pslverr = err_reg;
   assign prdata  = prdata_reg;

   // ****************************************************************
   // per-compound control
   // ****************************************************************
   genvar k;
   generate
   for (k = 0; k < 2; k = k + 1)
   begin : g_cmp
      reg  [31:0]              cfg_reg;
      reg  [31:0]              setp_reg;
      reg  [31:0]              lim_reg;
      reg  [31:0]              thr_reg;
      reg  [31:0]              rng_reg;
      reg  [31:0]              enl_reg;
      reg  [31:0]              shf_reg;
      reg  [32*MAX_STAGES-1:0] stg_reg;
      reg  [2:0]               mode_reg;
      reg  [4:0]               n_reg;
      reg  [11:0]              tmr_reg;
      reg  [15:0]              meas_reg;
      reg  [15:0]              ws_reg;
      reg                      warn_reg;
      reg                      haz_reg;
      reg  [9:0]               util_reg;
      reg  [MAX_STAGES-1:0]    out_reg;
      reg  [2:0]               mode_next;
      reg  [4:0]               n_next;
      reg  [11:0]              tmr_next;
      reg  [9:0]               util_next;
      reg  [4:0]               ncomp;
      integer                  i;

      wire        sel     = (k == 0) ? ~paddr[`CSS_CMP_BIT] : paddr[`CSS_CMP_BIT];
      wire        wr      = apb_wr & sel;
      wire [11:0] raw_s   = sync2_reg[k*12 +: 12];
      wire [11:0] brine_s = sync2_reg[24 + k*12 +: 12];
      wire [7:0]  t_s     = sync2_reg[48 + k*8 +: 8];
      wire [7:0]  h_s     = sync2_reg[64 + k*8 +: 8];
      wire        night_s = sync2_reg[80 + k];
      wire        chiller = (cfg_reg[`CSS_CFG_PLANT] != `CSS_PLANT_REFR);

      // register writes
      always @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            cfg_reg  <= `CSS_CFG_RST;
            setp_reg <= `CSS_REG_RST;
            lim_reg  <= `CSS_LIM_RST;
            thr_reg  <= `CSS_REG_RST;
            rng_reg  <= `CSS_RNG_RST;
            enl_reg  <= `CSS_REG_RST;
            shf_reg  <= `CSS_REG_RST;
            stg_reg  <= {MAX_STAGES{`CSS_REG_RST}};
         end
         else if (ce && wr)
         begin
            case (dec)
               `CSS_DEC_CFG:  cfg_reg  <= pwdata;
               `CSS_DEC_SETP: setp_reg <= pwdata;
               `CSS_DEC_LIM:  lim_reg  <= pwdata;
               `CSS_DEC_THR:  thr_reg  <= pwdata;
               `CSS_DEC_RNG:  rng_reg  <= pwdata;
               `CSS_DEC_ENL:  enl_reg  <= pwdata;
               `CSS_DEC_SHF:  shf_reg  <= pwdata;
               `CSS_DEC_STAGE:
                  stg_reg[paddr[5:2]*32 +: 32] <= pwdata;
               default:       cfg_reg  <= cfg_reg;
            endcase
         end
      end

      // measured value: chiller reads brine temperature channel
      wire [11:0] sel_raw  = chiller ? brine_s : raw_s;
      wire [27:0] prod     = sel_raw * rng_reg[31:16];
      wire [16:0] meas_sum = {1'b0, rng_reg[15:0]} + {1'b0, prod[27:12]};
      wire [15:0] meas_now = meas_sum[16] ? 16'hFFFF : meas_sum[15:0];

      // enthalpy shift between limits
      wire [7:0]  t_lo = enl_reg[7:0];
      wire [7:0]  t_hi = enl_reg[15:8];
      wire [7:0]  h_lo = enl_reg[23:16];
      wire [7:0]  h_hi = enl_reg[31:24];
      wire [7:0]  t_sp = (t_hi > t_lo) ? t_hi - t_lo : 8'h00;
      wire [7:0]  h_sp = (h_hi > h_lo) ? h_hi - h_lo : 8'h00;
      wire [7:0]  t_d  = (t_s >= t_hi) ? 8'h00 : (t_s <= t_lo) ? t_sp : t_hi - t_s;
      wire [7:0]  h_d  = (h_s >= h_hi) ? 8'h00 : (h_s <= h_lo) ? h_sp : h_hi - h_s;
      wire [10:0] num4 = {({1'b0, t_d} + {1'b0, h_d}), 2'b00};
      wire [8:0]  den  = {1'b0, t_sp} + {1'b0, h_sp};
      wire [10:0] den1 = {2'b00, den};
      wire [10:0] den2 = {1'b0, den, 1'b0};
      wire [10:0] den3 = den1 + den2;
      wire [2:0]  q    = (den == 9'h000) ? 3'h0 :
                         {2'b00, num4 >= den1} + {2'b00, num4 >= den2}
                         + {2'b00, num4 >= den3} + {2'b00, num4 >= {den, 2'b00}};
      wire [18:0] sh_p = shf_reg[15:0] * q;
      wire [16:0] shft = cfg_reg[`CSS_CFG_ENTH] ? sh_p[18:2] : 17'h00000;

      // working setpoint with offset, shift and ceiling
      wire [18:0] offs   = night_s ? {{3{lim_reg[31]}}, lim_reg[31:16]} : 19'h00000;
      wire [18:0] ws_sum = {3'b000, setp_reg[15:0]} + offs + {2'b00, shft};
      wire [15:0] ws_now = ws_sum[18] ? 16'h0000 :
                           (ws_sum > {3'b000, lim_reg[15:0]}) ? lim_reg[15:0] :
                           ws_sum[15:0];

      // hysteresis band around working setpoint
      wire [15:0] hw    = setp_reg[31:16];
      wire [18:0] ws19  = {3'b000, ws_reg};
      wire [18:0] hw19  = {3'b000, hw};
      wire [18:0] hh19  = {4'b0000, hw[15:1]};
      wire [1:0]  place = cfg_reg[`CSS_CFG_PLACE];
      wire [18:0] b_hi  = (place == `CSS_PLACE_ABV) ? ws19 + hw19 :
                          (place == `CSS_PLACE_BLW) ? ws19 : ws19 + hh19;
      wire [18:0] b_lo  = (place == `CSS_PLACE_ABV) ? ws19 :
                          (place == `CSS_PLACE_BLW) ? ws19 - hw19 : ws19 - (hw19 - hh19);
      wire [18:0] m19   = {3'b000, meas_reg};
      wire        above = $signed(m19) > $signed(b_hi);
      wire        below = $signed(m19) < $signed(b_lo);

      // stage configuration checks
      wire [4:0]  total  = cfg_reg[`CSS_CFG_TOTAL];
      wire        cfg_err = ({27'h0, total} > MAX_STAGES) || (ncomp > `CSS_MAX_COMPR);
      wire        hold    = haz_reg | cfg_err;
      wire [4:0]  n_fi    = ({27'h0, n_reg} < MAX_STAGES) ? n_reg : 5'h00;
      wire [4:0]  n_bi    = (n_reg != 5'h00) ? n_reg - 5'h01 : 5'h00;
      wire [11:0] fwd_dly = stg_reg[n_fi*32 + `CSS_STG_FWD +: 12];
      wire [11:0] bck_dly = stg_reg[n_bi*32 + `CSS_STG_BCK +: 12];

      // band state and stage stepping
      always @*
      begin
         ncomp = 5'h00;
         for (i = 0; i < MAX_STAGES; i = i + 1)
            if (i < total && css_first(i, cfg_reg[`CSS_CFG_PER]))
               ncomp = ncomp + 5'h01;
         if (above)
            mode_next = ST_FWD;
         else if (below)
            mode_next = ST_BCK;
         else
            mode_next = ST_NEU;
         n_next   = n_reg;
         tmr_next = 12'h000;
         if (hold)
            n_next = 5'h00;
         else if (mode_next != mode_reg)
            tmr_next = 12'h000;
         else
         begin
            case (mode_reg)
               ST_FWD:
               begin
                  if (n_reg < total)
                  begin
                     if (tmr_reg >= fwd_dly)
                        n_next = n_reg + 5'h01;
                     else
                        tmr_next = tick ? tmr_reg + 12'h001 : tmr_reg;
                  end
               end
               ST_BCK:
               begin
                  if (n_reg != 5'h00)
                  begin
                     if (tmr_reg >= bck_dly)
                        n_next = n_reg - 5'h01;
                     else
                        tmr_next = tick ? tmr_reg + 12'h001 : tmr_reg;
                  end
               end
               default: tmr_next = 12'h000;
            endcase
         end
         util_next = 10'h000;
         for (i = 0; i < MAX_STAGES; i = i + 1)
            if (i < n_next && css_first(i, cfg_reg[`CSS_CFG_PER]))
               util_next = util_next + {3'b000, stg_reg[i*32 + `CSS_STG_SHARE +: 7]};
      end

      // state registers
      always @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            mode_reg <= ST_NEU;
            n_reg    <= 5'h00;
            tmr_reg  <= 12'h000;
            meas_reg <= 16'h0000;
            ws_reg   <= 16'h0000;
            warn_reg <= 1'b0;
            haz_reg  <= 1'b0;
            util_reg <= 10'h000;
            out_reg  <= {MAX_STAGES{1'b0}};
         end
         else if (ce)
         begin
            mode_reg <= mode_next;
            n_reg    <= n_next;
            tmr_reg  <= tmr_next;
            meas_reg <= meas_now;
            ws_reg   <= ws_now;
            warn_reg <= (meas_now < thr_reg[15:0]);
            haz_reg  <= (meas_now < thr_reg[31:16]);
            util_reg <= util_next;
            for (i = 0; i < MAX_STAGES; i = i + 1)
               out_reg[i] <= (i < n_next);
         end
      end

      // read data and outputs
      reg [31:0] rd;
      always @*
      begin
         case (dec)
            `CSS_DEC_CFG:   rd = cfg_reg;
            `CSS_DEC_SETP:  rd = setp_reg;
            `CSS_DEC_LIM:   rd = lim_reg;
            `CSS_DEC_THR:   rd = thr_reg;
            `CSS_DEC_RNG:   rd = rng_reg;
            `CSS_DEC_ENL:   rd = enl_reg;
            `CSS_DEC_SHF:   rd = shf_reg;
            `CSS_DEC_STAT:  rd = {6'h00, util_reg, 3'h0, n_reg, 2'h0, cfg_err,
                                  haz_reg, warn_reg, mode_reg};
            `CSS_DEC_VAL:   rd = {meas_reg, ws_reg};
            `CSS_DEC_STAGE: rd = stg_reg[paddr[5:2]*32 +: 32];
            default:        rd = 32'h0000_0000;
         endcase
      end

      assign rd_all[k*32 +: 32]                  = rd;
      assign cfg_all[k*32 +: 32]                 = cfg_reg;
      assign stage_on[k*MAX_STAGES +: MAX_STAGES] = out_reg;
      assign forward_cmd[k]                      = mode_reg[1];
      assign backrun_cmd[k]                      = mode_reg[2];
      assign prealarm_warn[k]                    = warn_reg;
      assign prealarm_prio[k*2 +: 2]             = shf_reg[17:16];
      assign hazard_return[k]                    = haz_reg;
      assign utilization_pct[k*10 +: 10]         = util_reg;
   end
   endgenerate

endmodule

/* File: tb/compressor_stage_sequencer_tb_top.sv */
/* self-checking bench of the sequencer over apb and plant pins.
   assumes tick of 4 clocks and a plant model on the suction input. */
`timescale 1ns/1ps
module compressor_stage_sequencer_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr, lvl;
   logic [31:0] pwdata, prdata, rd, v, seed;
   logic [23:0] stage_on, suction_raw;
   logic [19:0] util;
   logic [3:0]  prio;
   logic [1:0]  night, fwd, bck, warn, hz;
   int          err_count, samples_checked;
   css_plant_model css_plant_model_i (.pclk(pclk), .level0(lvl), .suction_raw(suction_raw));
   css_sequencer #(.TICK_CYCLES(4)) css_sequencer_i (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .suction_raw(suction_raw), .brine_temp_raw(24'h000000),
      .plant_temp(16'h0000), .plant_hum(16'h0000), .night_shift_input(night),
      .stage_on(stage_on), .forward_cmd(fwd), .backrun_cmd(bck), .prealarm_warn(warn),
      .prealarm_prio(prio), .hazard_return(hz), .utilization_pct(util));
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   function logic [31:0] util_of(input int n);
      return n * 32'h32;
   endfunction
   task results;
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 50)
      begin
         err_count++;
         results();
      end
   endtask
   task wstg(input logic [11:0] e);
      int n;
      for (n = 0; n < 300 && stage_on[11:0] !== e; n++)
         @(posedge pclk);
      chk({20'h0, stage_on[11:0]}, {20'h0, e});
      if (n == 300)
         results();
   endtask
   task wait_cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, night, err_count, samples_checked} = '0;
      lvl = 12'h800;
      seed = 32'hc66a95d8;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 12'h000, 0);
      chk(rd, 32'h0);
      apb(0, 12'h008, 0);
      chk(rd, 32'h0000FFFF);
      apb(0, 12'h010, 0);
      chk(rd, 32'hFFFF0000);
      apb(0, 12'h030, 0);
      chk(er, 1'b1);
      apb(1, 12'h01C, 0);
      chk(er, 1'b1);
      apb(1, 12'h000, 32'h3);
      apb(1, 12'h080, 32'h2);
      chk(er, 1'b1);
      apb(1, 12'h080, 32'h1);
      chk(er, 1'b0);
      apb(1, 12'h010, 32'h10000000);
      apb(1, 12'h004, 32'h01000800);
      apb(1, 12'h00C, 32'h02000300);
      apb(1, 12'h018, 32'h00020000);
      apb(1, 12'h040, 32'h32003003);
      apb(1, 12'h044, 32'h32003008);
      apb(1, 12'h000, 32'h20);
      repeat (8)
      begin
         v = $random(seed);
         @(posedge pclk);
         lvl <= 12'h788 + v[11:0] % 12'h0F0;
         wait_cyc(8);
         chk({fwd[0], bck[0]}, 0);
      end
      lvl <= 12'hA00;
      wstg(12'h001);
      chk(fwd[0], 1'b1);
      apb(0, 12'h01C, 0);
      chk(rd[2:0], 3'h2);
      lvl <= 12'h800;
      wait_cyc(40);
      chk(stage_on[11:0], 12'h001);
      lvl <= 12'hA00;
      wstg(12'h003);
      wait_cyc(3);
      chk(util[9:0], util_of(2));
      lvl <= 12'h600;
      wstg(12'h001);
      chk(bck[0], 1'b1);
      wstg(12'h000);
      apb(1, 12'h008, 32'h0200FFFF);
      night <= 2'h1;
      lvl <= 12'hA00;
      wait_cyc(20);
      chk(fwd[0], 1'b0);
      apb(0, 12'h020, 0);
      chk(rd[15:0], 16'hA00);
      apb(1, 12'h008, 32'h02000900);
      wait_cyc(6);
      apb(0, 12'h020, 0);
      chk(rd[15:0], 16'h900);
      night <= 2'h0;
      wstg(12'h003);
      lvl <= 12'h100;
      wait_cyc(10);
      chk({warn[0], prio[1:0], hz[0]}, 4'hD);
      chk(stage_on[11:0], 12'h000);
      lvl <= 12'hA00;
      wait_cyc(8);
      chk(stage_on[11:0], 12'h000);
      wstg(12'h001);
      results();
   end
endmodule

/* File: tb/css_checker.sv */
/* port assertions for the sequencer, compound0 half.
   assumes bind onto css_sequencer. */
`timescale 1ns/1ps
module css_checker #(
   parameter MAX_STAGES = 12
) (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire logic [2*MAX_STAGES-1:0] stage_on,
   input wire logic [1:0]              forward_cmd,
   input wire logic [1:0]              backrun_cmd,
   input wire logic [1:0]              hazard_return,
   input wire logic [19:0]             utilization_pct
);
   wire [MAX_STAGES-1:0] s0 = stage_on[MAX_STAGES-1:0];
   wire                  hz = hazard_return[0];
   wire                  f0 = forward_cmd[0];
   wire                  b0 = backrun_cmd[0];
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_excl; !(f0 && b0); endproperty
   a_excl: assert property (p_excl) else $error("both commands");
   property p_haz; hz |=> s0 == '0; endproperty
   a_haz: assert property (p_haz) else $error("stages on in hazard");
   property p_up; |(s0 & ~$past(s0)) |-> $past(f0) && !$past(hz); endproperty
   a_up: assert property (p_up) else $error("stage on without forward");
   property p_dn; |(~s0 & $past(s0)) |-> $past(b0) || hz || $past(hz); endproperty
   a_dn: assert property (p_dn) else $error("stage off without backrun");
   property p_step; !hz && !$past(hz) |-> $countones(s0 ^ $past(s0)) <= 1; endproperty
   a_step: assert property (p_step) else $error("multi stage step");
   property p_neut; !f0 && !b0 && !hz && $past(!f0 && !b0) |-> $stable(s0); endproperty
   a_neut: assert property (p_neut) else $error("switch in neutral");
   property p_util; (s0 == '0)[*2] |-> utilization_pct[9:0] == 10'h000; endproperty
   a_util: assert property (p_util) else $error("util without stages");
   property p_rst; $fell(hz) |-> s0 == '0; endproperty
   a_rst: assert property (p_rst) else $error("instant restart");
   cover property (f0 ##1 |s0);
   cover property (hz);
   cover property (b0 && |s0);
endmodule
bind css_sequencer css_checker #(.MAX_STAGES(MAX_STAGES)) css_checker_i (
   .pclk(pclk), .presetn(presetn), .stage_on(stage_on), .forward_cmd(forward_cmd),
   .backrun_cmd(backrun_cmd), .hazard_return(hazard_return),
   .utilization_pct(utilization_pct));

/* File: tb/css_plant_model.sv */
/* suction transmitter model: registered 12-bit loop reading per compound.
   assumes the bench sets the wanted level of compound0. */
`timescale 1ns/1ps
module css_plant_model (
   // clock and wanted level
   input  wire logic        pclk,
   input  wire logic [11:0] level0,
   // transmitter readings
   output logic      [23:0] suction_raw = 24'h000000
);
   always @(posedge pclk)
      suction_raw <= {12'h7FF, level0};
endmodule
